// *** common/wwd_pkg.sv ***
// Package for the window watchdog block: timing constants, modes and carriers.
// Assumes a 50 MHz core clock; analog front ends deliver digital levels.
package wwd_pkg;

   localparam int CLK_HZ = 50000000;
   // Factory windows, in microseconds as printed (ms figures times 1000).
   localparam longint OPEN_LOWER_US = 800000;
   localparam longint OPEN_UPPER_US = 1600000;
   localparam longint PULL_LOWER_US = 1850;
   localparam longint PULL_UPPER_US = 11000;
   // Capacitor mode: upper = 77.4 s/uF * C + 0.055 s; 77.4 s/uF = 77.4 us/pF.
   localparam longint CAP_SLOPE_NS_PER_PF = 77400;
   localparam longint CAP_OFFSET_US = 55000;
   // Charge reference 1.21 V at 375 nA: 3226.67 ns per pF of capacitance.
   localparam longint CHARGE_NS_PER_PF_X100 = 322667;
   // Comparator must stay tripped this long before reset is taken.
   localparam longint UV_FILTER_NS = 100;
   localparam longint UV_DEEP_FILTER_NS = 40;

   localparam int CW = 32;
   localparam logic [CW-1:0] OPEN_LOWER_CYC = CW'(OPEN_LOWER_US * CLK_HZ / 1000000);
   localparam logic [CW-1:0] OPEN_UPPER_CYC = CW'(OPEN_UPPER_US * CLK_HZ / 1000000);
   localparam logic [CW-1:0] PULL_LOWER_CYC = CW'(PULL_LOWER_US * CLK_HZ / 1000000);
   localparam logic [CW-1:0] PULL_UPPER_CYC = CW'(PULL_UPPER_US * CLK_HZ / 1000000);
   localparam logic [CW-1:0] CAP_OFFSET_CYC = CW'(CAP_OFFSET_US * CLK_HZ / 1000000);
   // Cycles of upper window per cycle of capacitor charge: 77400/3226.67.
   localparam logic [CW-1:0] CAP_RATIO_X100 =
      CW'(CAP_SLOPE_NS_PER_PF * 10000 / CHARGE_NS_PER_PF_X100);
   localparam logic [CW-1:0] UV_FILTER_CYC =
      CW'((UV_FILTER_NS * CLK_HZ + 999999999) / 1000000000);
   localparam logic [CW-1:0] UV_DEEP_CYC =
      CW'((UV_DEEP_FILTER_NS * CLK_HZ + 999999999) / 1000000000);
   localparam logic [CW-1:0] CNT_ONE = CW'(1);
   localparam logic [CW-1:0] PCT_100 = CW'(100);
   localparam logic [CW-1:0] PCT_85 = CW'(85);
   localparam logic [CW-1:0] CNT_MAX = '1;

   typedef enum logic [1:0]
   {
      SRC_OPEN = 2'h0,
      SRC_PULLUP = 2'h1,
      SRC_CAP = 2'h2
   } wwd_src_t;

   typedef enum logic [1:0]
   {
      ST_DETECT = 2'h0,
      ST_CHARGE = 2'h1,
      ST_RUN = 2'h2
   } wwd_state_t;

   // Analog front end levels sampled by the logic.
   typedef struct packed
   {
      logic supply_ok;      // Supply at or above minimum operating level.
      logic uv_trip;        // Undervoltage comparator below threshold.
      logic uv_deep;        // Comparator overdrive is large.
      logic pin_high;       // Timing pin reads high with no charge current.
      logic pin_pulled;     // Timing pin holds high against a weak sink.
      logic pin_at_ref;     // Timing pin has reached the charge reference.
   } wwd_afe_t;

   typedef struct packed
   {
      logic charge_en;      // Constant current source on the timing pin.
      logic reset_out_n;    // Reset level, low while asserted.
      logic fault_oe;       // Fault pin pulled low while high.
   } wwd_out_t;

endpackage

// *** testbench/testbench.sv ***
// Self-checking bench for the window watchdog core.
// Assumes the pin front end is modelled here from the chosen mode.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import wwd_pkg::*;
   logic clk;
   logic reset_n;
   wwd_afe_t afe;
   logic mr_n;
   logic rel;
   logic en;
   logic ce;
   logic kick_req;
   logic kick;
   logic [1:0] mode;
   wwd_out_t pins;
   wwd_src_t src;
   logic fault_out;
   logic fault_oe;
   int bad_count;
   int checks;
   int chg;
   logic [31:0] rnd;
   wwd_core DUT (.clk(clk), .reset_n(reset_n), .clk_en(ce), .afe(afe),
      .manual_reset_input_n(mr_n), .reset_release(rel), .watchdog_enable_pin(en),
      .watchdog_kick_in(kick), .pins(pins), .watchdog_fault_out(fault_out),
      .watchdog_fault_oe(fault_oe), .window_source(src));
   wwd_host u_host (.clk(clk), .kick_req(kick_req), .kick(kick));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // The pin reaches the reference after 40 cycles of charge.
   always @(posedge clk)
   begin
      chg <= pins.charge_en ? chg + 1 : 0;
      afe.pin_high <= mode < 2'h2;
      afe.pin_pulled <= mode == 2'h1;
      afe.pin_at_ref <= chg >= 40;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      #1;
      checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("Error %s expected %0h seen %0h", n, e, g);
      end
      // Return on an edge so that the caller's next input change lands on it.
      @(posedge clk);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic kick_once;
      kick_req <= 1'b1;
      cyc(1);
      kick_req <= 1'b0;
      cyc(3);
   endtask
   task automatic restart(input logic [1:0] m);
      int i;
      mode <= m;
      mr_n <= 1'b0;
      cyc(3);
      kick_once();
      chk("fault_oe", 0, fault_oe);
      mr_n <= 1'b1;
      cyc(4);
      for (i = 0; i < 500 && pins.charge_en !== 1'b0; i++)
         cyc(1);
      if (i == 500)
      begin
         bad_count++;
         stop_test();
      end
      cyc(2);
   endtask
   task automatic dip(input int n, input logic d);
      afe.uv_trip <= 1'b1;
      afe.uv_deep <= d;
      cyc(n);
      afe.uv_trip <= 1'b0;
      afe.uv_deep <= 1'b0;
      cyc(3);
   endtask
   initial
   begin
      reset_n = 1'b0;
      afe = '0;
      afe.supply_ok = 1'b1;
      mr_n = 1'b1;
      rel = 1'b1;
      en = 1'b1;
      ce = 1'b1;
      kick_req = 1'b0;
      mode = 2'h1;
      chg = 0;
      rnd = 32'h1A1E;
      cyc(20);
      reset_n <= 1'b1;
      for (int m = 0; m < 3; m++)
      begin
         restart(2'(m));
         chk("window_source", 32'(m), 32'(src));
         mode <= (m == 0) ? 2'h1 : 2'h0;
         cyc(5);
         chk("window_source", 32'(m), 32'(src));
      end
      $display("test sources done");
      restart(2'h1);
      kick_once();
      chk("fault_oe", 0, fault_oe);
      rnd = lfsr(rnd);
      cyc(10 + int'(rnd[9:0]));
      kick_once();
      chk("fault_oe", 1, fault_oe);
      cyc(int'(PULL_LOWER_CYC) + 50);
      kick_once();
      chk("fault_oe", 0, fault_oe);
      rnd = lfsr(rnd);
      cyc(10 + int'(rnd[9:0]));
      kick_once();
      chk("fault_oe", 1, fault_oe);
      en <= 1'b0;
      kick_once();
      chk("fault_oe", 0, fault_oe);
      en <= 1'b1;
      $display("test window done");
      // A long dip while the core is frozen must not be counted.
      ce <= 1'b0;
      dip(6, 1'b0);
      chk("reset_out_n", 1, pins.reset_out_n);
      ce <= 1'b1;
      rel <= 1'b0;
      rnd = lfsr(rnd);
      dip(1 + int'(rnd[0]), 1'b0);
      chk("reset_out_n", 1, pins.reset_out_n);
      dip(6, 1'b0);
      chk("reset_out_n", 0, pins.reset_out_n);
      rel <= 1'b1;
      cyc(3);
      rel <= 1'b0;
      dip(2, 1'b1);
      chk("reset_out_n", 0, pins.reset_out_n);
      rel <= 1'b1;
      afe.supply_ok <= 1'b0;
      kick_once();
      chk("reset_out_n", 0, pins.reset_out_n);
      chk("fault_oe", 0, fault_oe);
      afe.supply_ok <= 1'b1;
      cyc(3);
      $display("test supply done");
      stop_test();
   end
endmodule
`default_nettype wire

// *** testbench/wwd_core_sva.sv ***
// Port checker for the window watchdog core.
// Checks rest while reset is applied or the clock enable holds the core frozen.
`timescale 1ns/1ps
`default_nettype none
module wwd_core_chk
   import wwd_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire wwd_afe_t afe,
   input wire logic watchdog_enable_pin,
   input wire wwd_out_t pins,
   input wire logic watchdog_fault_out,
   input wire logic watchdog_fault_oe,
   input wire wwd_src_t window_source
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n || !clk_en);
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_long_dip;
      afe.uv_trip [*5];
   endsequence
   sequence s_deep_dip;
      (afe.uv_trip && afe.uv_deep) [*2];
   endsequence
   property p_low_supply;
      !afe.supply_ok |-> !pins.reset_out_n;
   endproperty
   property p_fault_gate;
      !pins.reset_out_n |-> !watchdog_fault_oe;
   endproperty
   property p_cap_src;
      $fell(pins.charge_en) && pins.reset_out_n |-> ##[0:1] window_source == SRC_CAP;
   endproperty
   property p_cap_stop;
      pins.charge_en && afe.pin_at_ref |=> !pins.charge_en;
   endproperty
   property p_long_dip;
      s_long_dip |-> ##[0:3] !pins.reset_out_n;
   endproperty
   property p_deep_dip;
      s_deep_dip |-> ##[0:3] !pins.reset_out_n;
   endproperty
   property p_disable;
      !watchdog_enable_pin |-> !watchdog_fault_oe;
   endproperty
   property p_fault_low;
      watchdog_fault_oe |-> !watchdog_fault_out;
   endproperty
   property p_src_hold;
      pins.reset_out_n [*6] ##0 !$past(pins.charge_en) |-> $stable(window_source);
   endproperty
   a_low_supply: assert property (p_low_supply)
      else $error("reset released at low supply");
   a_fault_gate: assert property (p_fault_gate)
      else $error("fault driven during reset");
   a_cap_src: assert property (p_cap_src)
      else $error("charge ended without capacitor source");
   a_cap_stop: assert property (p_cap_stop)
      else $error("charge kept past reference");
   a_long_dip: assert property (p_long_dip)
      else $error("long dip gave no reset");
   a_deep_dip: assert property (p_deep_dip)
      else $error("deep dip gave no reset");
   a_disable: assert property (p_disable)
      else $error("fault driven while disabled");
   a_fault_low: assert property (p_fault_low)
      else $error("fault level not low");
   a_src_hold: assert property (p_src_hold)
      else $error("timing source changed in run");
endmodule
bind wwd_core wwd_core_chk u_chk (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .afe(afe),
   .watchdog_enable_pin(watchdog_enable_pin), .pins(pins),
   .watchdog_fault_out(watchdog_fault_out), .watchdog_fault_oe(watchdog_fault_oe),
   .window_source(window_source));
`default_nettype wire

// *** testbench/wwd_host.sv ***
// Host model that services the watchdog kick input.
// Assumes the bench asks for each kick, early ones included.
`timescale 1ns/1ps
`default_nettype none
module wwd_host
(
   input wire logic clk,
   input wire logic kick_req,
   output logic kick
);
   initial kick = 1'b1;
   always @(posedge clk)
      kick <= !kick_req;
endmodule
`default_nettype wire

// *** verilog/wwd_core.sv ***
// Window watchdog supervisor logic: timing source, window checks and outputs.
// Assumes the analog front end gives synchronous levels and a reset-time
// release handshake; reset_out_n and the fault pin are open drain outside.
//
// How it works
// - Below minimum operating supply, reset output stays low regardless of kicks.
// - While reset is asserted, the fault pin is released to high impedance.
// - Open or pulled-up timing pin gives factory windows; capacitor gives scaled.
// - Open pin: lower window 800 ms, upper 1600 ms typical.
// - Pulled-up pin: lower window 1.85 ms, upper 11.0 ms typical.
// - Capacitor charged by constant current to reference; interval sets window length.
// - Capacitor upper window equals 77.4 s per uF plus 0.055 s.
// - Capacitor lower window is half the upper; spread 0.85 to 1.15.
// - Short supply dips are filtered; long or deep dips assert reset.
// - Enable pin low disables watchdog, ignores kicks, fault pin released.
// - After first kick, falling edges outside the window assert the fault.
// - First kick has no lower window; must come before the upper.
// - Kicks ignored during reset; window checks resume after release.
`timescale 1ns/1ps
`default_nettype none

module wwd_core
   import wwd_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire wwd_afe_t afe,
   input wire logic manual_reset_input_n,
   input wire logic reset_release,
   input wire logic watchdog_enable_pin,
   input wire logic watchdog_kick_in,
   output wwd_out_t pins,
   output logic watchdog_fault_out,
   output logic watchdog_fault_oe,
   output wwd_src_t window_source
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   wwd_state_t state_q, state_d;
   wwd_src_t src_q, src_d;
   logic [CW-1:0] uv_cnt_q, uv_cnt_d;
   logic uv_rst_q, uv_rst_d;
   logic [CW-1:0] win_cnt_q, win_cnt_d;
   logic [CW-1:0] charge_q, charge_d;
   logic [CW-1:0] lower_q, lower_d;
   logic [CW-1:0] upper_q, upper_d;
   logic first_q, first_d;
   logic kick_q, kick_d;
   logic fault_q, fault_d;
   logic rst_hold;
   logic kick_fall;
   logic [CW-1:0] cap_upper;

   assign rst_hold = !afe.supply_ok || uv_rst_q || !manual_reset_input_n;
   assign kick_fall = kick_q && !watchdog_kick_in;
   assign cap_upper = CW'((64'(charge_q) * 64'(CAP_RATIO_X100)) / 64'(PCT_100))
                      + CAP_OFFSET_CYC;

   // -----------------------------------------------------------------
   // Supply supervision
   // -----------------------------------------------------------------
   always_comb
   begin
      uv_cnt_d = uv_cnt_q;
      uv_rst_d = uv_rst_q;
      if (!afe.uv_trip)
      begin
         uv_cnt_d = '0;
         if (reset_release)
            uv_rst_d = 1'b0;
      end
      else
      begin
         if (uv_cnt_q != CNT_MAX)
            uv_cnt_d = uv_cnt_q + CNT_ONE;
         // Deep overdrive needs a shorter stay below threshold.
         if (uv_cnt_q + CNT_ONE >= (afe.uv_deep ? UV_DEEP_CYC : UV_FILTER_CYC))
            uv_rst_d = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         uv_cnt_q <= '0;
         uv_rst_q <= 1'b1;
      end
      else if (clk_en)
      begin
         uv_cnt_q <= uv_cnt_d;
         uv_rst_q <= uv_rst_d;
      end
   end

   // -----------------------------------------------------------------
   // Timing source detection and window checking
   // -----------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      src_d = src_q;
      win_cnt_d = win_cnt_q;
      charge_d = charge_q;
      lower_d = lower_q;
      upper_d = upper_q;
      first_d = first_q;
      fault_d = fault_q;
      kick_d = watchdog_kick_in;
      if (rst_hold)
      begin
         state_d = ST_DETECT;
         first_d = 1'b1;
         fault_d = 1'b0;
         win_cnt_d = '0;
      end
      else
      begin
         unique case (state_q)
            ST_DETECT:
            begin
               charge_d = '0;
               win_cnt_d = '0;
               if (afe.pin_high && afe.pin_pulled)
               begin
                  src_d = SRC_PULLUP;
                  lower_d = PULL_LOWER_CYC;
                  upper_d = PULL_UPPER_CYC;
                  state_d = ST_RUN;
               end
               else if (afe.pin_high)
               begin
                  src_d = SRC_OPEN;
                  lower_d = OPEN_LOWER_CYC;
                  upper_d = OPEN_UPPER_CYC;
                  state_d = ST_RUN;
               end
               else
               begin
                  src_d = SRC_CAP;
                  state_d = ST_CHARGE;
               end
            end
            ST_CHARGE:
            begin
               if (afe.pin_at_ref)
               begin
                  upper_d = cap_upper;
                  lower_d = cap_upper >> 1;
                  state_d = ST_RUN;
               end
               else if (charge_q != CNT_MAX)
                  charge_d = charge_q + CNT_ONE;
            end
            ST_RUN:
            begin
               if (!watchdog_enable_pin)
               begin
                  win_cnt_d = '0;
                  first_d = 1'b1;
                  fault_d = 1'b0;
               end
               else if (kick_fall)
               begin
                  // first edge has no lower bound
                  if (!first_q && (win_cnt_q < lower_q))
                     fault_d = 1'b1;
                  else
                     fault_d = 1'b0;
                  first_d = 1'b0;
                  win_cnt_d = '0;
               end
               else
               begin
                  if (win_cnt_q != CNT_MAX)
                     win_cnt_d = win_cnt_q + CNT_ONE;
                  if (win_cnt_q + CNT_ONE >= upper_q)
                  begin
                     fault_d = 1'b1;
                     win_cnt_d = '0;
                  end
               end
            end
            default:
               state_d = ST_DETECT;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         state_q <= ST_DETECT;
         src_q <= SRC_OPEN;
         win_cnt_q <= '0;
         charge_q <= '0;
         lower_q <= OPEN_LOWER_CYC;
         upper_q <= OPEN_UPPER_CYC;
         first_q <= 1'b1;
         kick_q <= 1'b1;
         fault_q <= 1'b0;
      end
      else if (clk_en)
      begin
         state_q <= state_d;
         src_q <= src_d;
         win_cnt_q <= win_cnt_d;
         charge_q <= charge_d;
         lower_q <= lower_d;
         upper_q <= upper_d;
         first_q <= first_d;
         kick_q <= kick_d;
         fault_q <= fault_d;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // The pin is only ever pulled low; the fault output level is constant.
   assign watchdog_fault_out = 1'b0;
   assign watchdog_fault_oe = fault_q && !rst_hold && watchdog_enable_pin;
   assign pins.fault_oe = watchdog_fault_oe;
   assign pins.reset_out_n = !rst_hold;
   assign pins.charge_en = (state_q == ST_CHARGE) && !rst_hold;
   assign window_source = src_q;

endmodule

`default_nettype wire
